// ### hcls_stacks.sv
`timescale 1ns/1ps
`include "hcls_map.svh"
module hcls_stacks import hcls_pkg::*; (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic irq_taken_i,
  output logic stack_irq_req_o,
  output logic [31:0] stack_isr_table_base_o,
  output logic [1:0] rounding_select_o,
  output logic [1:0] shift_select_o,
  output logic low_word_shift_o
);
  logic [15:0] call_mem [16];
  logic [48:0] loop_mem [8];
  hcls_loop_t active_q;
  logic [3:0] call_idx_q, call_idx_d, call_hi_q, call_lo_q;
  logic [2:0] loop_idx_q, loop_idx_d, loop_hi_q, loop_lo_q;
  logic [7:0] call_cfg_q, loop_cfg_q;
  logic [13:0] stq_base_q;
  logic [3:0] sticky_q, ev;
  logic [3:0] step;
  logic [3:0] call_wslot;
  logic [2:0] loop_wslot;
  logic int_q, intp_q, ls_q;
  logic [1:0] round_q, shift_q;
  logic [31:0] rdata_q;
  logic wr_ph_q;
  logic [7:0] waddr_q;
  logic [7:0] raddr;
  logic rd_go, wr_go;
  logic [3:0] call_top;
  logic [2:0] loop_top;
  hcls_loop_t lst_top;
  hcls_mode_t mode;

  assign rd_go = hsel_i && hready_i && htrans_i[1] && !hwrite_i;
  assign raddr = haddr_i[7:0];
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign hrdata_o = rdata_q;
  assign call_top = call_idx_q - 4'd1;
  assign loop_top = loop_idx_q - 3'd1;
  assign lst_top = hcls_loop_t'(loop_mem[loop_top]);
  assign call_wslot = (call_cfg_q[`HCLS_CFG_WEN] && call_cfg_q[`HCLS_CFG_WDIR]) ? call_idx_q : call_top;
  assign loop_wslot = (loop_cfg_q[`HCLS_CFG_WEN] && loop_cfg_q[`HCLS_CFG_WDIR]) ? loop_idx_q : loop_top;
  assign wr_go = wr_ph_q;

  always_comb begin
    mode = '0;
    mode.sticky = sticky_q;
    mode.call_idx = call_idx_q;
    mode.prior_irq_enable = intp_q;
    mode.loop_idx = loop_idx_q;
    mode.irq_global_enable = int_q;
    mode.low_word_shift = ls_q;
    mode.rounding_select = hcls_round_t'(round_q);
    mode.shift_select = hcls_shift_t'(shift_q);
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      wr_ph_q <= 1'b0;
      waddr_q <= 8'h00;
    end else begin
      wr_ph_q <= hsel_i && hready_i && htrans_i[1] && hwrite_i;
      waddr_q <= raddr;
    end
  end

  // Index update on top access
  always_comb begin
    call_idx_d = call_idx_q;
    loop_idx_d = loop_idx_q;
    step = 4'b0000;
    if (wr_go && waddr_q == `HCLS_A_CALL_TOP && call_cfg_q[`HCLS_CFG_WEN]) begin
      step[3] = call_cfg_q[`HCLS_CFG_WDIR];
      step[2] = !call_cfg_q[`HCLS_CFG_WDIR];
    end else if (rd_go && raddr == `HCLS_A_CALL_TOP && call_cfg_q[`HCLS_CFG_REN]) begin
      step[3] = call_cfg_q[`HCLS_CFG_RDIR];
      step[2] = !call_cfg_q[`HCLS_CFG_RDIR];
    end
    if (wr_go && waddr_q == `HCLS_A_LST_KC && loop_cfg_q[`HCLS_CFG_WEN]) begin
      step[1] = loop_cfg_q[`HCLS_CFG_WDIR];
      step[0] = !loop_cfg_q[`HCLS_CFG_WDIR];
    end else if (rd_go && raddr == `HCLS_A_LST_KC && loop_cfg_q[`HCLS_CFG_REN]) begin
      step[1] = loop_cfg_q[`HCLS_CFG_RDIR];
      step[0] = !loop_cfg_q[`HCLS_CFG_RDIR];
    end
    // Direct index writes never step
    if (wr_go && (waddr_q == `HCLS_A_CALL_IDX || waddr_q == `HCLS_A_MODE)) begin
      step[3:2] = 2'b00;
    end
    if (wr_go && (waddr_q == `HCLS_A_LOOP_IDX || waddr_q == `HCLS_A_MODE)) begin
      step[1:0] = 2'b00;
    end
    if (step[3]) begin
      call_idx_d = call_idx_q + 4'd1;
    end
    if (step[2]) begin
      call_idx_d = call_idx_q - 4'd1;
    end
    if (step[1]) begin
      loop_idx_d = loop_idx_q + 3'd1;
    end
    if (step[0]) begin
      loop_idx_d = loop_idx_q - 3'd1;
    end
    if (wr_go && waddr_q == `HCLS_A_CALL_IDX) begin
      call_idx_d = hwdata_i[3:0];
    end
    if (wr_go && waddr_q == `HCLS_A_LOOP_IDX) begin
      loop_idx_d = hwdata_i[2:0];
    end
    if (wr_go && waddr_q == `HCLS_A_MODE) begin
      call_idx_d = hwdata_i[15:12];
      loop_idx_d = hwdata_i[10:8];
    end
  end

  // Overflow and underflow detect
  always_comb begin
    ev = 4'b0000;
    ev[3] = step[3] && call_idx_q == call_hi_q && call_cfg_q[`HCLS_CFG_OVFM];
    ev[2] = step[2] && call_idx_d == call_lo_q && call_cfg_q[`HCLS_CFG_UNFM];
    ev[1] = step[1] && loop_idx_q == loop_hi_q && loop_cfg_q[`HCLS_CFG_OVFM];
    ev[0] = step[0] && loop_idx_d == loop_lo_q && loop_cfg_q[`HCLS_CFG_UNFM];
  end

  assign stack_irq_req_o = (|sticky_q[3:2] && call_cfg_q[`HCLS_CFG_IEN])
    || (|sticky_q[1:0] && loop_cfg_q[`HCLS_CFG_IEN]);

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      call_idx_q <= 4'h0;
      loop_idx_q <= 3'h0;
    end else begin
      call_idx_q <= call_idx_d;
      loop_idx_q <= loop_idx_d;
    end
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      sticky_q <= 4'h0;
    end else if (wr_go && waddr_q == `HCLS_A_STICKY) begin
      sticky_q <= (sticky_q & ~hwdata_i[3:0]) | ev;
    end else if (wr_go && waddr_q == `HCLS_A_MODE) begin
      sticky_q <= hwdata_i[19:16] | ev;
    end else begin
      sticky_q <= sticky_q | ev;
    end
  end

  always_ff @(posedge clock_i) begin
    if (wr_go && waddr_q == `HCLS_A_CALL_TOP) begin
      call_mem[call_wslot] <= hwdata_i[15:0];
    end
    if (wr_go && waddr_q == `HCLS_A_LST_BND) begin
      loop_mem[loop_wslot][48:17] <= hwdata_i;
    end
    if (wr_go && waddr_q == `HCLS_A_LST_KC) begin
      loop_mem[loop_wslot][16:0] <= hwdata_i[16:0];
    end
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      active_q <= '0;
    end else if (wr_go && waddr_q == `HCLS_A_LP_BND) begin
      active_q.end_addr <= hwdata_i[31:16];
      active_q.begin_addr <= hwdata_i[15:0];
    end else if (wr_go && waddr_q == `HCLS_A_LP_KC) begin
      active_q.patch <= hwdata_i[16];
      active_q.count <= hwdata_i[15:0];
    end
  end

  // Configuration and limits
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      call_cfg_q <= 8'h00;
      loop_cfg_q <= 8'h00;
      call_hi_q <= 4'h0;
      call_lo_q <= 4'h0;
      loop_hi_q <= 3'h0;
      loop_lo_q <= 3'h0;
      stq_base_q <= 14'(`HCLS_STQ_RST >> 2);
    end else if (wr_go) begin
      case (waddr_q)
        `HCLS_A_CALL_CFG: call_cfg_q <= hwdata_i[7:0];
        `HCLS_A_LOOP_CFG: loop_cfg_q <= hwdata_i[7:0];
        `HCLS_A_CALL_HI: call_hi_q <= hwdata_i[3:0];
        `HCLS_A_CALL_LO: call_lo_q <= hwdata_i[3:0];
        `HCLS_A_LOOP_HI: loop_hi_q <= hwdata_i[2:0];
        `HCLS_A_LOOP_LO: loop_lo_q <= hwdata_i[2:0];
        `HCLS_A_STQ_BASE: stq_base_q <= hwdata_i[15:2];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      int_q <= 1'b0;
      intp_q <= 1'b0;
      ls_q <= 1'b0;
      round_q <= 2'b00;
      shift_q <= 2'b00;
    end else begin
      if (wr_go && waddr_q == `HCLS_A_MODE) begin
        int_q <= hwdata_i[`HCLS_MODE_INT];
        intp_q <= hwdata_i[`HCLS_MODE_INTP];
        ls_q <= hwdata_i[`HCLS_MODE_LS];
        round_q <= hwdata_i[3:2];
        shift_q <= hwdata_i[1:0];
      end
      if (wr_go && waddr_q == `HCLS_A_ROUND) begin
        round_q <= hwdata_i[3:2];
      end
      if (wr_go && waddr_q == `HCLS_A_SHIFT) begin
        shift_q <= hwdata_i[1:0];
      end
      if (wr_go && waddr_q == `HCLS_A_IRQ) begin
        int_q <= hwdata_i[0];
        intp_q <= hwdata_i[1];
      end
      if (irq_taken_i) begin
        intp_q <= int_q;
      end
    end
  end

  // Read data
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd_go) begin
      case (raddr)
        `HCLS_A_STQ_BASE: rdata_q <= {16'h0000, stq_base_q, 2'b00};
        `HCLS_A_CALL_IDX: rdata_q <= {28'h000_0000, call_idx_q};
        `HCLS_A_CALL_TOP: rdata_q <= {16'h0000, call_mem[call_top]};
        `HCLS_A_LOOP_IDX: rdata_q <= {29'h0000_0000, loop_idx_q};
        `HCLS_A_LP_BND: rdata_q <= {active_q.end_addr, active_q.begin_addr};
        `HCLS_A_LP_KC: rdata_q <= {15'h0000, active_q.patch, active_q.count};
        `HCLS_A_LST_BND: rdata_q <= {lst_top.end_addr, lst_top.begin_addr};
        `HCLS_A_LST_KC: rdata_q <= {15'h0000, lst_top.patch, lst_top.count};
        `HCLS_A_CALL_HI: rdata_q <= {28'h000_0000, call_hi_q};
        `HCLS_A_CALL_LO: rdata_q <= {28'h000_0000, call_lo_q};
        `HCLS_A_LOOP_HI: rdata_q <= {29'h0000_0000, loop_hi_q};
        `HCLS_A_LOOP_LO: rdata_q <= {29'h0000_0000, loop_lo_q};
        `HCLS_A_MODE: rdata_q <= {12'h000, mode};
        `HCLS_A_CALL_CFG: rdata_q <= {24'h00_0000, call_cfg_q};
        `HCLS_A_LOOP_CFG: rdata_q <= {24'h00_0000, loop_cfg_q};
        `HCLS_A_ROUND: rdata_q <= {28'h000_0000, round_q, 2'b00};
        `HCLS_A_SHIFT: rdata_q <= {30'h0000_0000, shift_q};
        `HCLS_A_STICKY: rdata_q <= {28'h000_0000, sticky_q};
        `HCLS_A_IRQ: rdata_q <= {30'h0000_0000, intp_q, int_q};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  assign stack_isr_table_base_o = {16'h0000, stq_base_q, 2'b00};
  assign rounding_select_o = round_q;
  assign shift_select_o = shift_q;
  assign low_word_shift_o = ls_q;
endmodule

// ### hcls_map.svh
// How it works
// - 4-bit call index names next push slot; mirrored in mode bits 15:12.
// - Call top word reads entry at (call index - 1) mod 16.
// - 3-bit loop index mirrored in mode 10:8; top is (index - 1) mod 8.
// - Active loop first word: end address 31:16, begin address 15:0.
// - Second loop word bit 16 gives kind: 0 loop, 1 patch block.
// - Second loop word bits 15:0 hold iteration count or patch length.
// - Call overflow when index steps up past high limit and enabled.
// - Call underflow when index steps down onto low limit and enabled.
// - Loop overflow when index steps up past high limit and enabled.
// - Loop underflow when index steps down onto low limit and enabled.
// - Alias registers read and write chosen mode fields alone.
// - Sticky mode bits 19..16 record call ovf, call unf, loop ovf, loop unf.
// - Every interrupt copies global enable into prior-enable bit 11.
// - Mode bit 4 set shifts low accumulator word right one bit.
// - Mode 3:2 picks rounding: none, add half, toward zero, dither.
// - Mode 1:0 picks shift: 00 none, 01 shift right.
// - Handler table base held in bits 15:2, others reserved.
// - Auto-update on top write steps index up if direction one, else down.
// - Stack enable bit gates taking requests; masked events still queue.
// - Call stack 16 x 16 bits, loop stack 8 x 49 bits circular.
`ifndef HCLS_MAP_SVH
`define HCLS_MAP_SVH
`define HCLS_A_STQ_BASE 8'h00
`define HCLS_A_CALL_IDX 8'h04
`define HCLS_A_CALL_TOP 8'h08
`define HCLS_A_LOOP_IDX 8'h0C
`define HCLS_A_LP_BND 8'h10
`define HCLS_A_LP_KC 8'h14
`define HCLS_A_LST_BND 8'h18
`define HCLS_A_LST_KC 8'h1C
`define HCLS_A_CALL_HI 8'h20
`define HCLS_A_CALL_LO 8'h24
`define HCLS_A_LOOP_HI 8'h28
`define HCLS_A_LOOP_LO 8'h2C
`define HCLS_A_MODE 8'h30
`define HCLS_A_CALL_CFG 8'h34
`define HCLS_A_LOOP_CFG 8'h38
`define HCLS_A_ROUND 8'h3C
`define HCLS_A_SHIFT 8'h40
`define HCLS_A_STICKY 8'h44
`define HCLS_A_IRQ 8'h48
`define HCLS_STQ_RST 32'h0000_0020
`define HCLS_STQ_MASK 32'h0000_FFFC
`define HCLS_CFG_WDIR 7
`define HCLS_CFG_WEN 6
`define HCLS_CFG_RDIR 5
`define HCLS_CFG_REN 4
`define HCLS_CFG_OVFM 3
`define HCLS_CFG_UNFM 2
`define HCLS_CFG_IEN 1
`define HCLS_MODE_LS 4
`define HCLS_MODE_INT 7
`define HCLS_MODE_INTP 11
`endif

// ### hcls_pkg.sv
package hcls_pkg;
  typedef enum logic [1:0] {
    HCLS_ROUND_NONE,
    HCLS_ROUND_HALF,
    HCLS_ROUND_ZERO,
    HCLS_ROUND_DITHER
  } hcls_round_t;
  typedef enum logic [1:0] {
    HCLS_SHIFT_NONE,
    HCLS_SHIFT_RIGHT,
    HCLS_SHIFT_RIGHT2,
    HCLS_SHIFT_LEFT
  } hcls_shift_t;
  typedef struct packed {
    logic [15:0] end_addr;
    logic [15:0] begin_addr;
    logic patch;
    logic [15:0] count;
  } hcls_loop_t;
  typedef struct packed {
    logic [3:0] sticky;
    logic [3:0] call_idx;
    logic prior_irq_enable;
    logic [2:0] loop_idx;
    logic irq_global_enable;
    logic [1:0] rsvd;
    logic low_word_shift;
    hcls_round_t rounding_select;
    hcls_shift_t shift_select;
  } hcls_mode_t;
endpackage

// ### hcls_stacks_checker.sv
`timescale 1ns/1ps
module hcls_stacks_checker (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic [31:0] hrdata_o,
  input wire logic stack_irq_req_o,
  input wire logic [31:0] stack_isr_table_base_o,
  input wire logic [1:0] rounding_select_o,
  input wire logic [1:0] shift_select_o,
  input wire logic low_word_shift_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  // Taken address phase, then its data phase
  sequence s_acc(logic w, logic [7:0] a);
    hsel_i && hready_i && htrans_i[1] && hwrite_i == w && haddr_i[7:0] == a ##1 1'b1;
  endsequence
  property p_base_rsvd; stack_isr_table_base_o[1:0] == 2'h0 && stack_isr_table_base_o[31:16] == 16'h0000; endproperty
  a_base_rsvd: assert property (p_base_rsvd) else $error("base reserved bits set");
  property p_base_wr; s_acc(1'b1, 8'h00) |=> stack_isr_table_base_o == ($past(hwdata_i) & 32'h0000_FFFC); endproperty
  a_base_wr: assert property (p_base_wr) else $error("base write lost");
  property p_base_rd; s_acc(1'b0, 8'h00) |-> hrdata_o == $past(stack_isr_table_base_o); endproperty
  a_base_rd: assert property (p_base_rd) else $error("base read wrong");
  property p_round; s_acc(1'b1, 8'h3C) |=> rounding_select_o == $past(hwdata_i[3:2]); endproperty
  a_round: assert property (p_round) else $error("rounding alias wrong");
  property p_shift; s_acc(1'b1, 8'h40) |=> shift_select_o == $past(hwdata_i[1:0]); endproperty
  a_shift: assert property (p_shift) else $error("shift alias wrong");
  property p_alias_iso; s_acc(1'b1, 8'h3C) |=> $stable(shift_select_o) && $stable(low_word_shift_o); endproperty
  a_alias_iso: assert property (p_alias_iso) else $error("alias touched other field");
  property p_lws; s_acc(1'b1, 8'h30) |=> low_word_shift_o == $past(hwdata_i[4]); endproperty
  a_lws: assert property (p_lws) else $error("low word shift wrong");
  property p_mode_rd; s_acc(1'b0, 8'h30) |-> hrdata_o[4] == $past(low_word_shift_o)
    && hrdata_o[3:2] == $past(rounding_select_o) && hrdata_o[1:0] == $past(shift_select_o); endproperty
  a_mode_rd: assert property (p_mode_rd) else $error("mode read fields wrong");
  property p_rst_quiet; $fell(reset_i) |-> !stack_irq_req_o; endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("request after reset");
  property p_okay; hreadyout_o && !hresp_o; endproperty
  a_okay: assert property (p_okay) else $error("bus response not ready and okay");
endmodule
bind hcls_stacks hcls_stacks_checker i_chk (.clock_i(clock_i), .reset_i(reset_i), .hsel_i(hsel_i),
  .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hwdata_i(hwdata_i), .hready_i(hready_i),
  .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
  .hrdata_o(hrdata_o), .stack_irq_req_o(stack_irq_req_o), .stack_isr_table_base_o(stack_isr_table_base_o),
  .rounding_select_o(rounding_select_o), .shift_select_o(shift_select_o), .low_word_shift_o(low_word_shift_o));

// ### test_hw_call_and_loop_stacks.sv
`timescale 1ns/1ps
module test_hw_call_and_loop_stacks;
  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  logic hwrite_i = 1'b0;
  logic irq_i = 1'b0;
  logic [1:0] htrans_i = 2'h0;
  logic [31:0] haddr_i = 32'h0000_0000;
  logic [31:0] hwdata_i = 32'h0000_0000;
  logic [31:0] hrdata_o, base_o;
  logic rdy_o, irq_o, lws_o;
  logic [1:0] rnd_o, sh_o;
  int n_errors = 0;
  int n_compared = 0;
  always #50 clock_i = ~clock_i;
  hcls_stacks i_dut (.clock_i(clock_i), .reset_i(reset_i), .hsel_i(1'b1), .haddr_i(haddr_i), .htrans_i(htrans_i),
    .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i), .hready_i(rdy_o), .hrdata_o(hrdata_o),
    .hreadyout_o(rdy_o), .hresp_o(), .irq_taken_i(irq_i), .stack_irq_req_o(irq_o),
    .stack_isr_table_base_o(base_o), .rounding_select_o(rnd_o), .shift_select_o(sh_o), .low_word_shift_o(lws_o));
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_rdy();
    int n;
    n = 0;
    do @(posedge clock_i); while (rdy_o !== 1'b1 && ++n < 20);
    if (n == 20) begin
      n_errors++;
      end_of_test();
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    hwrite_i <= w;
    haddr_i <= {24'h00_0000, a};
    htrans_i <= 2'h2;
    wait_rdy();
    htrans_i <= 2'h0;
    hwdata_i <= d;
    wait_rdy();
    r = hrdata_o;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0000_0000, r);
    check(r & m, e);
  endtask
  task automatic t_reset_base();
    rc(8'h04, 32'hFFFF_FFFF, 32'h0000_0000);
    rc(8'h0C, 32'hFFFF_FFFF, 32'h0000_0000);
    rc(8'h10, 32'hFFFF_FFFF, 32'h0000_0000);
    rc(8'h14, 32'hFFFF_FFFF, 32'h0000_0000);
    rc(8'h30, 32'h000F_F700, 32'h0000_0000);
    rc(8'h00, 32'hFFFF_FFFF, 32'h0000_0020);
    wr(8'h00, 32'hFFFF_FFFF);
    rc(8'h00, 32'hFFFF_FFFF, 32'h0000_FFFC);
    check(base_o, 32'h0000_FFFC);
    rc(8'h99, 32'hFFFF_FFFF, 32'h0000_0000);
    $display("reset and base done");
  endtask
  task automatic t_call();
    wr(8'h34, 32'h0000_00C0);
    wr(8'h04, 32'h0000_000E);
    wr(8'h08, 32'h0000_A001);
    rc(8'h08, 32'h0000_FFFF, 32'h0000_A001);
    rc(8'h30, 32'h0000_F000, 32'h0000_F000);
    wr(8'h08, 32'h0000_A002);
    rc(8'h04, 32'hFFFF_FFFF, 32'h0000_0000);
    rc(8'h08, 32'hFFFF_FFFF, 32'h0000_A002);
    wr(8'h34, 32'h0000_0040);
    wr(8'h08, 32'h0000_A003);
    rc(8'h04, 32'hFFFF_FFFF, 32'h0000_000F);
    wr(8'h34, 32'h0000_0030);
    rc(8'h08, 32'hFFFF_FFFF, 32'h0000_A001);
    rc(8'h04, 32'hFFFF_FFFF, 32'h0000_0000);
    $display("call stack done");
  endtask
  task automatic t_call_events();
    wr(8'h20, 32'h0000_0003);
    wr(8'h24, 32'h0000_0001);
    wr(8'h34, 32'h0000_00C2);
    wr(8'h04, 32'h0000_0003);
    wr(8'h08, 32'h0000_0001);
    rc(8'h30, 32'h000F_0000, 32'h0000_0000);
    wr(8'h34, 32'h0000_00CE);
    wr(8'h04, 32'h0000_0003);
    wr(8'h08, 32'h0000_0001);
    rc(8'h30, 32'h000F_0000, 32'h0008_0000);
    check(32'(irq_o), 32'h0000_0001);
    wr(8'h34, 32'h0000_004C);
    wr(8'h04, 32'h0000_0002);
    wr(8'h08, 32'h0000_0001);
    rc(8'h30, 32'h000F_0000, 32'h000C_0000);
    check(32'(irq_o), 32'h0000_0000);
    wr(8'h44, 32'h0000_000F);
    rc(8'h30, 32'h000F_0000, 32'h0000_0000);
    $display("call events done");
  endtask
  task automatic t_loop();
    wr(8'h28, 32'h0000_0007);
    wr(8'h2C, 32'h0000_0007);
    wr(8'h38, 32'h0000_000E);
    wr(8'h0C, 32'h0000_0007);
    wr(8'h18, 32'h1234_5678);
    wr(8'h1C, 32'h0001_00AA);
    rc(8'h18, 32'hFFFF_FFFF, 32'h1234_5678);
    rc(8'h1C, 32'hFFFF_FFFF, 32'h0001_00AA);
    wr(8'h38, 32'h0000_00CE);
    wr(8'h1C, 32'h0000_0005);
    rc(8'h30, 32'h000F_0700, 32'h0002_0000);
    wr(8'h38, 32'h0000_004E);
    wr(8'h1C, 32'h0000_0005);
    rc(8'h30, 32'h000F_0700, 32'h0003_0700);
    wr(8'h10, 32'hBEEF_0042);
    wr(8'h14, 32'hFFFF_FFFF);
    rc(8'h10, 32'hFFFF_FFFF, 32'hBEEF_0042);
    rc(8'h14, 32'hFFFF_FFFF, 32'h0001_FFFF);
    $display("loop stack done");
  endtask
  task automatic t_mode();
    for (int i = 0; i < 4; i++) begin
      wr(8'h3C, 32'(i) << 2);
      wr(8'h40, 32'(i));
      @(posedge clock_i);
      check(32'(rnd_o), 32'(i));
      check(32'(sh_o), 32'(i));
    end
    wr(8'h3C, 32'h0000_0003);
    rc(8'h30, 32'h0000_001F, 32'h0000_0003);
    wr(8'h30, 32'h0000_0010);
    @(posedge clock_i);
    check(32'(lws_o), 32'h0000_0001);
    wr(8'h48, 32'h0000_0001);
    irq_i <= 1'b1;
    @(posedge clock_i);
    irq_i <= 1'b0;
    rc(8'h30, 32'h0000_0880, 32'h0000_0880);
    wr(8'h48, 32'h0000_0002);
    irq_i <= 1'b1;
    @(posedge clock_i);
    irq_i <= 1'b0;
    rc(8'h30, 32'h0000_0880, 32'h0000_0000);
    $display("mode fields done");
  endtask
  initial begin
    repeat (2) @(posedge clock_i);
    reset_i <= 1'b0;
    @(posedge clock_i);
    t_reset_base();
    t_call();
    t_call_events();
    t_loop();
    t_mode();
    end_of_test();
  end
endmodule
